// ==== hw/energy_cfg_pkg.sv ====
// Constants, field layout and carrier types for the energy accumulation
// configuration block.
// Assumes one 25 MHz clock domain and a plain address/strobe register port.
package energy_cfg_pkg;

  // Widths of samples, bus and energy registers
  localparam int SAMPLE_W = 15;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int ENERGY_W = 32;
  localparam int NUM_PHASES = 3;
  localparam int NUM_ENERGY = 15;

  // Register addresses
  localparam logic [ADDR_W-1:0] ACC_MODE_ADDR = 16'hE701;
  localparam logic [ADDR_W-1:0] LINE_CYCLE_ADDR = 16'hE702;
  localparam logic [ADDR_W-1:0] ENERGY_BASE_ADDR = 16'hE400;
  localparam logic [ADDR_W-1:0] NUM_ENERGY_ADDR = 16'h000F;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 16'hE500;
  localparam logic [ADDR_W-1:0] MASK_ADDR = 16'hE501;
  localparam logic [ADDR_W-1:0] LC_COUNT_ADDR = 16'hE502;

  // Field positions in accumulation_mode_upper
  localparam int TOPO_LSB = 4;
  localparam int REV_ACT_SEL_BIT = 6;
  localparam int REV_REACT_SEL_BIT = 7;

  // Field positions in line_cycle_control
  localparam int LC_ACTIVE_BIT = 0;
  localparam int LC_REACTIVE_BIT = 1;
  localparam int LC_APPARENT_BIT = 2;
  localparam int ZX_SEL_LSB = 3;
  localparam int CLEAR_ON_READ_BIT = 6;

  // Field positions in primary_event_flags
  localparam int LC_DONE_BIT = 5;
  localparam int REV_ACT_LSB = 6;
  localparam int REV_REACT_LSB = 10;

  // Reset values and implemented-bit masks
  localparam logic [7:0] ACC_MODE_RESET = 8'h00;
  localparam logic [7:0] LINE_CYCLE_RESET = 8'h78;
  localparam logic [7:0] LINE_CYCLE_WMASK = 8'h7F;
  localparam logic [DATA_W-1:0] STATUS_IMPL = 32'h0000_1DE0;
  localparam logic [DATA_W-1:0] MASK_RESET = 32'h0000_0000;
  localparam logic [15:0] LC_COUNT_RESET = 16'h0064;

  // Energy kinds; channel index is kind * 3 + phase
  localparam int KIND_ACTIVE = 0;
  localparam int KIND_FUND_ACTIVE = 1;
  localparam int KIND_REACTIVE = 2;
  localparam int KIND_FUND_REACTIVE = 3;
  localparam int KIND_APPARENT = 4;

  // Wiring topology codes
  typedef enum logic [1:0] {
    TOPO_4W_3V = 2'b00,
    TOPO_3W_DELTA = 2'b01,
    TOPO_4W_2V = 2'b10,
    TOPO_4W_DELTA = 2'b11
  } wiring_topology_t;

  // One register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  // Per-phase measurement inputs, valid with sample_valid
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] volt;
    logic signed [SAMPLE_W-1:0] curr;
    logic signed [SAMPLE_W-1:0] curr_q90;
    logic [SAMPLE_W-1:0] volt_rms;
    logic [SAMPLE_W-1:0] curr_rms;
    logic signed [ENERGY_W-1:0] fund_active;
    logic signed [ENERGY_W-1:0] fund_reactive;
  } phase_in_t;

endpackage

// ==== hw/energy_accumulation_config.sv ====
// Energy accumulation configuration: wiring topology input selection,
// reverse-power flags, line-cycle and clear-on-read handling of 15 energy
// registers, with event flags, mask and one interrupt.
// Assumes all inputs synchronous to clock and one-cycle sample/zero-cross pulses.
// Functional notes
// - The topology field picks one of four wiring schemes for the accumulator inputs.
// - Reactive accumulators use the -90 degree shifted phase current.
// - Phase B uses VBxIB, zero, (-VA-VC)xIB or (-VA)xIB per topology code.
// - Phase A and C active inputs are always own voltage times own current.
// - With the active source select at 0 the reverse-active flags follow total power.
// - With the active source select at 1 the reverse-active flags follow fundamental power.
// - The reactive source select picks total or fundamental power for flags 10 to 12.
// - Line-cycle bit 0 puts the six watt-hour accumulators into line-cycle mode.
// - Line-cycle bit 1 puts the three var-hour accumulators into line-cycle mode.
// - Line-cycle bit 2 puts the three VA-hour accumulators into line-cycle mode.
// - Bits 3 to 5 enable zero-crossing counting per phase and reset to one.
// - Crossings of all enabled phases are counted together, shortening the period.
// - With clear-on-read set (default) a read of an energy register zeroes it.
// - Bit 7 of line-cycle control is reserved, reads zero and does nothing.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module energy_accumulation_config (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire energy_cfg_pkg::reg_req_t req,
  output logic [energy_cfg_pkg::DATA_W-1:0] rd_data,
  // Measurement inputs
  input wire logic sample_valid,
  input wire energy_cfg_pkg::phase_in_t [energy_cfg_pkg::NUM_PHASES-1:0] phase_in,
  input wire logic [energy_cfg_pkg::NUM_PHASES-1:0] zero_cross,
  // Events
  output logic line_cycle_end,
  output logic irq
);
  import energy_cfg_pkg::*;

  localparam int V_W = SAMPLE_W + 2;
  localparam int PROD_W = V_W + SAMPLE_W;

  // Configuration and status state
  logic [7:0] acc_mode_q;
  logic [7:0] acc_mode_d;
  logic [7:0] line_cycle_q;
  logic [7:0] line_cycle_d;
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] status_d;
  logic [DATA_W-1:0] mask_q;
  logic [DATA_W-1:0] mask_d;
  logic [15:0] lc_count_q;
  logic [15:0] lc_count_d;
  logic [15:0] zx_cnt_q;
  logic [15:0] zx_cnt_d;
  logic [DATA_W-1:0] rd_data_d;
  logic irq_d;

  // Write decode
  wire wr_acc_mode = req.wr && (req.addr == ACC_MODE_ADDR);
  wire wr_line_cycle = req.wr && (req.addr == LINE_CYCLE_ADDR);
  wire wr_status = req.wr && (req.addr == STATUS_ADDR);
  wire wr_mask = req.wr && (req.addr == MASK_ADDR);
  wire wr_lc_count = req.wr && (req.addr == LC_COUNT_ADDR);

  // Configuration fields
  wiring_topology_t topology;
  assign topology = wiring_topology_t'(acc_mode_q[TOPO_LSB +: 2]);
  wire rev_act_fund = acc_mode_q[REV_ACT_SEL_BIT];
  wire rev_react_fund = acc_mode_q[REV_REACT_SEL_BIT];
  wire lc_active = line_cycle_q[LC_ACTIVE_BIT];
  wire lc_reactive = line_cycle_q[LC_REACTIVE_BIT];
  wire lc_apparent = line_cycle_q[LC_APPARENT_BIT];
  wire [NUM_PHASES-1:0] zx_sel = line_cycle_q[ZX_SEL_LSB +: NUM_PHASES];
  wire clear_on_read = line_cycle_q[CLEAR_ON_READ_BIT];

  // Per-channel accumulator inputs and reverse-power events
  logic signed [ENERGY_W-1:0] addend [NUM_ENERGY];
  logic [NUM_PHASES-1:0] rev_act_evt;
  logic [NUM_PHASES-1:0] rev_react_evt;

  // Derived phase B voltages for the two-sensor and delta schemes
  wire signed [V_W-1:0] va_ext = V_W'(phase_in[0].volt);
  wire signed [V_W-1:0] vc_ext = V_W'(phase_in[2].volt);
  wire signed [V_W-1:0] vb_minus_a_c = -va_ext - vc_ext;
  wire signed [V_W-1:0] vb_minus_a = -va_ext;

  // Phase B is dead in three-wire delta
  wire phase_b_off = (topology == TOPO_3W_DELTA);

  // Input selection per phase
  for (genvar p = 0; p < NUM_PHASES; p++) begin : g_phase
    logic signed [V_W-1:0] v_sel;
    logic phase_on;
    logic signed [PROD_W-1:0] active_prod;
    logic signed [PROD_W-1:0] reactive_prod;
    logic [2*SAMPLE_W-1:0] apparent_prod;
    logic signed [ENERGY_W-1:0] fund_p;
    logic signed [ENERGY_W-1:0] fund_q;
    logic signed [ENERGY_W-1:0] act_src;
    logic signed [ENERGY_W-1:0] react_src;

    if (p == 1) begin : g_b
      // Derived voltage replaces the missing phase B sensor
      assign v_sel = (topology == TOPO_4W_2V) ? vb_minus_a_c :
                     (topology == TOPO_4W_DELTA) ? vb_minus_a :
                     V_W'(phase_in[p].volt);
      assign phase_on = !phase_b_off;
    end else begin : g_ac
      assign v_sel = V_W'(phase_in[p].volt);
      assign phase_on = 1'b1;
    end

    // Products; the reactive path uses the shifted current
    // Sized cast first: a bare '0 arm would turn the product unsigned
    assign active_prod = phase_on ? PROD_W'(v_sel * phase_in[p].curr) : '0;
    assign reactive_prod = phase_on ? PROD_W'(v_sel * phase_in[p].curr_q90) : '0;
    assign apparent_prod = phase_on ? phase_in[p].volt_rms * phase_in[p].curr_rms : '0;
    assign fund_p = phase_on ? phase_in[p].fund_active : '0;
    assign fund_q = phase_on ? phase_in[p].fund_reactive : '0;

    assign addend[KIND_ACTIVE*3+p] = ENERGY_W'(active_prod);
    assign addend[KIND_FUND_ACTIVE*3+p] = fund_p;
    assign addend[KIND_REACTIVE*3+p] = ENERGY_W'(reactive_prod);
    assign addend[KIND_FUND_REACTIVE*3+p] = fund_q;
    assign addend[KIND_APPARENT*3+p] = ENERGY_W'({1'b0, apparent_prod});

    // Reverse flag sources: total or fundamental per select bit
    assign act_src = rev_act_fund ? fund_p : ENERGY_W'(active_prod);
    assign react_src = rev_react_fund ? fund_q : ENERGY_W'(reactive_prod);
    assign rev_act_evt[p] = sample_valid && act_src[ENERGY_W-1];
    assign rev_react_evt[p] = sample_valid && react_src[ENERGY_W-1];
  end

  // Zero crossings from every enabled phase add to one shared count,
  // so enabling more phases shortens the period
  wire [NUM_PHASES-1:0] zx_hit = zero_cross & zx_sel;
  wire [1:0] zx_num = 2'({1'b0, zx_hit[0]} + {1'b0, zx_hit[1]} + {1'b0, zx_hit[2]});
  wire [16:0] zx_sum = {1'b0, zx_cnt_q} + {15'h0000, zx_num};
  // A zero count still ends the period at the first crossing
  wire period_end = (zx_num != 2'b00) && (zx_sum >= {1'b0, lc_count_q});
  assign zx_cnt_d = (period_end || wr_lc_count) ? 16'h0000 : zx_sum[15:0];

  // Energy read decode
  wire [ADDR_W-1:0] energy_offset = req.addr - ENERGY_BASE_ADDR;
  wire energy_hit = (energy_offset < NUM_ENERGY_ADDR);
  logic signed [ENERGY_W-1:0] energy_view [NUM_ENERGY];

  // Energy channels
  for (genvar e = 0; e < NUM_ENERGY; e++) begin : g_energy
    localparam int KIND = e / 3;
    logic signed [ENERGY_W-1:0] work_q;
    logic signed [ENERGY_W-1:0] work_d;
    logic signed [ENERGY_W-1:0] shown_q;
    logic signed [ENERGY_W-1:0] shown_d;
    logic lc_mode;
    logic rd_clear;
    logic signed [ENERGY_W-1:0] step;
    logic signed [ENERGY_W-1:0] sum;

    // Mode bit per kind; the fundamental var-hour set has no line-cycle bit
    if (KIND == KIND_ACTIVE || KIND == KIND_FUND_ACTIVE) begin : g_w
      assign lc_mode = lc_active;
    end else if (KIND == KIND_REACTIVE) begin : g_var
      assign lc_mode = lc_reactive;
    end else if (KIND == KIND_APPARENT) begin : g_va
      assign lc_mode = lc_apparent;
    end else begin : g_fvar
      assign lc_mode = 1'b0;
    end

    assign rd_clear = req.rd && clear_on_read &&
                      (req.addr == ADDR_W'(ENERGY_BASE_ADDR + e));
    assign step = sample_valid ? addend[e] : '0;
    assign sum = work_q + step;

    // Regular mode: the working sum is the register and a clearing read
    // keeps the sample of that same cycle, so no energy is lost
    // Line-cycle mode: the period total is latched and the sum restarts;
    // a latch in the same cycle as a clearing read wins over the clear
    assign work_d = !lc_mode ? (rd_clear ? step : sum) :
                    (period_end ? '0 : sum);
    assign shown_d = (lc_mode && period_end) ? sum :
                     (lc_mode && rd_clear) ? '0 : shown_q;
    assign energy_view[e] = lc_mode ? shown_q : work_q;

    // Accumulator registers
    always_ff @(posedge clock) begin
      if (!resetn) begin
        work_q <= '0;
        shown_q <= '0;
      end else begin
        work_q <= work_d;
        shown_q <= shown_d;
      end
    end
  end

  // Register writes; the reserved top bit never stores
  assign acc_mode_d = wr_acc_mode ? req.wdata[7:0] : acc_mode_q;
  assign line_cycle_d = wr_line_cycle ? (req.wdata[7:0] & LINE_CYCLE_WMASK) : line_cycle_q;
  assign mask_d = wr_mask ? (req.wdata & STATUS_IMPL) : mask_q;
  assign lc_count_d = wr_lc_count ? req.wdata[15:0] : lc_count_q;

  // Events set over a write-one clear in the same cycle
  wire [DATA_W-1:0] status_evt = (DATA_W'(rev_act_evt) << REV_ACT_LSB) |
                                 (DATA_W'(rev_react_evt) << REV_REACT_LSB) |
                                 (DATA_W'(period_end) << LC_DONE_BIT);
  wire [DATA_W-1:0] status_clr = wr_status ? req.wdata : '0;
  assign status_d = ((status_q & ~status_clr) | status_evt) & STATUS_IMPL;
  // Taken from the next values so irq tracks the flags without extra lag
  assign irq_d = |(status_d & mask_d);

  // Read mux; unmapped addresses and idle cycles return zero
  wire [DATA_W-1:0] energy_rd = DATA_W'(energy_view[energy_offset[3:0]]);
  assign rd_data_d = !req.rd ? '0 :
                     (req.addr == ACC_MODE_ADDR) ? {24'h00_0000, acc_mode_q} :
                     (req.addr == LINE_CYCLE_ADDR) ? {24'h00_0000, line_cycle_q} :
                     (req.addr == STATUS_ADDR) ? status_q :
                     (req.addr == MASK_ADDR) ? mask_q :
                     (req.addr == LC_COUNT_ADDR) ? {16'h0000, lc_count_q} :
                     energy_hit ? energy_rd : '0;

  // Configuration registers; zero-cross enables and clear-on-read reset to one
  always_ff @(posedge clock) begin
    if (!resetn) begin
      acc_mode_q <= ACC_MODE_RESET;
      line_cycle_q <= LINE_CYCLE_RESET;
      mask_q <= MASK_RESET;
      lc_count_q <= LC_COUNT_RESET;
    end else begin
      acc_mode_q <= acc_mode_d;
      line_cycle_q <= line_cycle_d;
      mask_q <= mask_d;
      lc_count_q <= lc_count_d;
    end
  end

  // Status, period counter and outputs
  always_ff @(posedge clock) begin
    if (!resetn) begin
      status_q <= '0;
      zx_cnt_q <= 16'h0000;
      rd_data <= '0;
      irq <= 1'b0;
      line_cycle_end <= 1'b0;
    end else begin
      status_q <= status_d;
      zx_cnt_q <= zx_cnt_d;
      rd_data <= rd_data_d;
      irq <= irq_d;
      line_cycle_end <= period_end;
    end
  end

endmodule // energy_accumulation_config

`default_nettype wire

// ==== sim/energy_cfg_assertions.sv ====
// Port checker for the energy accumulation configuration block.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module energy_cfg_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire energy_cfg_pkg::reg_req_t req,
  input wire logic [energy_cfg_pkg::DATA_W-1:0] rd_data,
  // Measurements and events
  input wire logic sample_valid,
  input wire energy_cfg_pkg::phase_in_t [energy_cfg_pkg::NUM_PHASES-1:0] phase_in,
  input wire logic [energy_cfg_pkg::NUM_PHASES-1:0] zero_cross,
  input wire logic line_cycle_end,
  input wire logic irq
);
  import energy_cfg_pkg::*;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // Read data stands only in the slot after a read
  property p_rd_idle;
    !$past(req.rd) |-> rd_data == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

  // Reserved top bit never reads back
  property p_lc_rsv;
    req.rd && req.addr == LINE_CYCLE_ADDR |=> rd_data[31:7] == '0;
  endproperty
  a_lc_rsv: assert property (p_lc_rsv) else $error("reserved bit set");

  // Mode register holds what was written
  property p_acc_rw;
    req.wr && req.addr == ACC_MODE_ADDR ##1 req.rd && req.addr == ACC_MODE_ADDR
      |=> rd_data == ($past(req.wdata, 2) & 32'h0000_00FF);
  endproperty
  a_acc_rw: assert property (p_acc_rw) else $error("mode readback wrong");

  // Line-cycle control keeps bits 6..0 only
  property p_lc_rw;
    req.wr && req.addr == LINE_CYCLE_ADDR ##1 req.rd && req.addr == LINE_CYCLE_ADDR
      |=> rd_data == ($past(req.wdata, 2) & 32'h0000_007F);
  endproperty
  a_lc_rw: assert property (p_lc_rw) else $error("line cycle readback wrong");

  // Status shows only its implemented flags
  property p_status_impl;
    req.rd && req.addr == STATUS_ADDR |=> (rd_data & ~STATUS_IMPL) == '0;
  endproperty
  a_status_impl: assert property (p_status_impl) else $error("stray status bit");

  // A period end needs a crossing the cycle before
  property p_lce_cause;
    line_cycle_end |-> $past(zero_cross) != '0;
  endproperty
  a_lce_cause: assert property (p_lce_cause) else $error("period end without crossing");

  // Clearing the mask drops the interrupt
  property p_mask_off;
    req.wr && req.addr == MASK_ADDR && req.wdata == '0 |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with empty mask");

  // Interrupt is low on leaving reset
  property p_irq_reset;
    $rose(resetn) |-> !irq;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("irq out of reset");

  // Main scenarios
  c_lce: cover property (line_cycle_end);
  c_irq: cover property (irq);
  c_flags: cover property (req.rd && req.addr == STATUS_ADDR ##1 rd_data != '0);
endmodule // energy_cfg_checker

bind energy_accumulation_config energy_cfg_checker u_chk (
  .clock(clock), .resetn(resetn), .req(req), .rd_data(rd_data),
  .sample_valid(sample_valid), .phase_in(phase_in), .zero_cross(zero_cross),
  .line_cycle_end(line_cycle_end), .irq(irq)
);

`default_nettype wire

// ==== sim/test_energy_accumulation_config.sv ====
// Self-checking bench for the energy accumulation configuration block.
// Assumes the package constants and the register port timing of the block.
`timescale 1ns/100ps
`default_nettype none

module test_energy_accumulation_config;
  import energy_cfg_pkg::*;
  logic clock;
  logic resetn;
  reg_req_t req;
  logic [DATA_W-1:0] rd_data;
  logic sample_valid;
  phase_in_t [NUM_PHASES-1:0] phase_in;
  logic [NUM_PHASES-1:0] zero_cross;
  logic line_cycle_end;
  logic irq;
  int n_mismatch;
  int comparisons;
  int seed;

  energy_accumulation_config u_dut (
    .clock(clock), .resetn(resetn), .req(req), .rd_data(rd_data),
    .sample_valid(sample_valid), .phase_in(phase_in), .zero_cross(zero_cross),
    .line_cycle_end(line_cycle_end), .irq(irq)
  );

  // Free-running 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One request per call; the next call replaces it, so strobes stay one cycle
  task automatic xfer(input logic w, input logic r, input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{w, r, a, d};
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    xfer(1'b1, 1'b0, a, d);
    xfer(1'b0, 1'b0, 16'h0000, 32'h0000_0000);
  endtask

  // Data is looked at mid-cycle, in its only valid slot
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    xfer(1'b0, 1'b1, a, 32'h0000_0000);
    xfer(1'b0, 1'b0, 16'h0000, 32'h0000_0000);
    @(negedge clock);
    chk(rd_data, e);
  endtask

  task automatic stim(input logic v, input logic [2:0] z);
    @(posedge clock);
    sample_valid <= v;
    zero_cross <= z;
  endtask

  task automatic rst();
    @(posedge clock);
    resetn <= 1'b0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
  endtask

  task automatic shuffle();
    logic [159:0] r;
    for (int p = 0; p < 3; p++) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      phase_in[p] <= r[138:0];
    end
  endtask

  // Instantaneous product feeding a phase accumulator under topology t
  function automatic logic [31:0] prod(input int p, input int t, input logic q);
    int v;
    int i;
    v = phase_in[p].volt;
    i = q ? phase_in[p].curr_q90 : phase_in[p].curr;
    if (p == 1 && t == 1) v = 0;
    if (p == 1 && t == 2) v = -phase_in[0].volt - phase_in[2].volt;
    if (p == 1 && t == 3) v = -phase_in[0].volt;
    return 32'(v * i);
  endfunction

  function automatic logic [31:0] vah(input int p, input int t);
    if (p == 1 && t == 1) return 32'h0000_0000;
    return 32'(phase_in[p].volt_rms) * 32'(phase_in[p].curr_rms);
  endfunction

  function automatic logic [31:0] sexp(input int t, input logic sa, input logic sr);
    logic [31:0] s;
    int fa;
    int fr;
    s = '0;
    for (int p = 0; p < 3; p++) begin
      fa = (p == 1 && t == 1) ? 0 : phase_in[p].fund_active;
      fr = (p == 1 && t == 1) ? 0 : phase_in[p].fund_reactive;
      s[REV_ACT_LSB + p] = sa ? fa < 0 : $signed(prod(p, t, 1'b0)) < 0;
      s[REV_REACT_LSB + p] = sr ? fr < 0 : $signed(prod(p, t, 1'b1)) < 0;
    end
    return s;
  endfunction

  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    logic [1:0] tt;
    resetn = 1'b0;
    req = '0;
    sample_valid = 1'b0;
    phase_in = '0;
    zero_cross = 3'b000;
    seed = 92;
    rst();
    rd(LINE_CYCLE_ADDR, 32'h0000_0078);
    rd(ACC_MODE_ADDR, 32'h0000_0000);
    rd(16'h1234, 32'h0000_0000);
    xfer(1'b1, 1'b0, LINE_CYCLE_ADDR, 32'h0000_00FF);
    rd(LINE_CYCLE_ADDR, 32'h0000_007F);
    xfer(1'b1, 1'b0, ACC_MODE_ADDR, 32'h0000_00A5);
    rd(ACC_MODE_ADDR, 32'h0000_00A5);
    // Each topology with one source-select pairing, random samples
    for (int t = 0; t < 4; t++) begin
      tt = t[1:0];
      rst();
      shuffle();
      wr(ACC_MODE_ADDR, {24'h0000_00, tt[1], tt[0], tt, 4'h0});
      stim(1'b1, 3'b000);
      stim(1'b0, 3'b000);
      rd(ENERGY_BASE_ADDR, prod(0, t, 1'b0));
      rd(ENERGY_BASE_ADDR + 16'h0001, prod(1, t, 1'b0));
      rd(ENERGY_BASE_ADDR + 16'h0002, prod(2, t, 1'b0));
      rd(ENERGY_BASE_ADDR + 16'h0006, prod(0, t, 1'b1));
      rd(ENERGY_BASE_ADDR + 16'h0007, prod(1, t, 1'b1));
      rd(ENERGY_BASE_ADDR + 16'h000D, vah(1, t));
      rd(ENERGY_BASE_ADDR + 16'h0001, 32'h0000_0000);
      wr(MASK_ADDR, STATUS_IMPL);
      rd(STATUS_ADDR, sexp(t, tt[0], tt[1]));
      chk({31'h0, irq}, {31'h0, sexp(t, tt[0], tt[1]) != '0});
      wr(STATUS_ADDR, 32'hFFFF_FFFF);
      rd(STATUS_ADDR, 32'h0000_0000);
      wr(MASK_ADDR, 32'h0000_0000);
    end
    // Line-cycle periods: one phase twice, then two phases at once
    for (int k = 0; k < 2; k++) begin
      rst();
      shuffle();
      wr(LC_COUNT_ADDR, 32'h0000_0002);
      wr(LINE_CYCLE_ADDR, k ? 32'h0000_003F : 32'h0000_000F); // Clear-on-read off
      stim(1'b1, k ? 3'b011 : 3'b001);
      if (k == 0) stim(1'b1, 3'b101); // Phase C crossing not enabled
      stim(1'b0, 3'b000);
      @(negedge clock);
      chk({31'h0, line_cycle_end}, 32'h0000_0001);
      stim(1'b1, 3'b000);
      stim(1'b0, 3'b000);
      rd(ENERGY_BASE_ADDR, 32'((2 - k) * prod(0, 0, 1'b0)));
      rd(ENERGY_BASE_ADDR, 32'((2 - k) * prod(0, 0, 1'b0)));
      rd(ENERGY_BASE_ADDR + 16'h0006, 32'((2 - k) * prod(0, 0, 1'b1)));
      rd(ENERGY_BASE_ADDR + 16'h000C, 32'((2 - k) * vah(0, 0)));
      rd(ENERGY_BASE_ADDR + 16'h0003, 32'((2 - k) * phase_in[0].fund_active));
      // Fundamental var-hour stays regular: every sample counts
      rd(ENERGY_BASE_ADDR + 16'h0009, 32'((3 - k) * phase_in[0].fund_reactive));
      rd(STATUS_ADDR, sexp(0, 1'b0, 1'b0) | 32'h0000_0020);
    end
    end_of_test();
  end
endmodule // test_energy_accumulation_config

`default_nettype wire
